// ==== lpm_pkg.sv ====
// Purpose: Shared constants for the low-power mode controller
// Assumes: 32-bit AXI4-Lite register bus, registers in the low byte
// Notes: Register indices are word indices; byte address is index * 4
package lpm_pkg;

    // Register word indices
    localparam logic [7:0] IDX_SYSCTL1 = 8'h38;
    localparam logic [7:0] IDX_SYSCTL2 = 8'h39;
    localparam logic [7:0] IDX_WAKECTL = 8'h3a;
    localparam logic [7:0] IDX_STATUS = 8'h3b;

    // system_control_one fields
    localparam int SC1_STOP = 7;
    localparam int SC1_STOP_RELEASE_METHOD = 6;
    localparam int SC1_STOP_RETURN_MODE = 5;
    localparam int SC1_OUTEN = 4;
    localparam int SC1_WUT_LO = 0;
    localparam int SC1_WUT_HI = 2;
    localparam logic [7:0] SC1_RESET = 8'h00;
    localparam logic [7:0] SC1_WMASK = 8'hf7;

    // system_control_two fields
    localparam int SC2_XEN = 7;
    localparam int SC2_XTEN = 6;
    localparam int SC2_SYSCK = 5;
    localparam int SC2_HALT = 4;
    localparam logic [7:0] SC2_RESET = 8'h80;
    localparam logic [7:0] SC2_WMASK = 8'hf0;

    // wakeup_release_control: enables for the four key wakeup inputs
    localparam int KEYS = 4;
    localparam int WK_LO = 2;
    localparam logic [7:0] WK_RESET = 8'h00;

    // Status register fields
    localparam int ST_STATE_LO = 0;
    localparam int ST_STOP_RELEASE_METHOD_EFF = 4;
    localparam int ST_FASTOSC = 5;
    localparam int ST_SLOWOSC = 6;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Warm-up counter width and the short warm-up counts
    localparam int WARM_W = 18;
    localparam logic [17:0] WARM_FAST_3X10 = 18'h0_0c00;
    localparam logic [17:0] WARM_FAST_1X10 = 18'h0_0400;
    localparam logic [17:0] WARM_SLOW_3X6 = 18'h0_00c0;
    localparam logic [17:0] WARM_SLOW_1X6 = 18'h0_0040;

    typedef enum logic [3:0] {
        ST_RUN = 4'b0001,
        ST_STOP = 4'b0010,
        ST_WARM = 4'b0100,
        ST_HALT = 4'b1000
    } lpm_state_t;

endpackage

// ==== warmup_counter.sv ====
// Purpose: Down counter that times the oscillator warm-up period
// Assumes: tick is a same-clock strobe; load wins over counting
// Notes: done pulses one cycle after the last counted tick
`timescale 1ns/1ps
module warmup_counter #(
    parameter int WIDTH = 18
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [WIDTH-1:0] loadValue,
    input wire logic tick,
    output logic done
);
    logic [WIDTH-1:0] cnt_r;

    initial begin
        if (WIDTH < 2) begin
            $error("warmup_counter WIDTH too small");
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
        end else if (load) begin
            cnt_r <= loadValue;
        end else if (tick && cnt_r != '0) begin
            cnt_r <= cnt_r - 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            done <= 1'b0;
        end else begin
            done <= !load && tick && (cnt_r == {{(WIDTH-1){1'b0}}, 1'b1});
        end
    end
endmodule

// ==== low_power_mode_control.sv ====
// Purpose: STOP and CPU-halt mode controller with an AXI4-Lite slave
// Assumes: stop pin and key inputs are asynchronous; CPU side is sync
// Notes: Every output and bus answer leaves a flip-flop
`timescale 1ns/1ps
module low_power_mode_control
    import lpm_pkg::*;
#(
    parameter int IRQS = 8,
    parameter logic [17:0] WARM_FAST_3X16 = 18'h3_0000,
    parameter logic [17:0] WARM_FAST_1X16 = 18'h1_0000,
    parameter logic [17:0] WARM_FAST_3X14 = 18'h0_c000,
    parameter logic [17:0] WARM_FAST_1X14 = 18'h0_4000,
    parameter logic [17:0] WARM_SLOW_3X13 = 18'h0_6000,
    parameter logic [17:0] WARM_SLOW_1X13 = 18'h0_2000
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [9:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [9:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic stopPinN,
    input wire logic [KEYS-1:0] keyWakeupInputs,
    input wire logic slowTick,
    input wire logic [15:0] instrAddr,
    input wire logic interruptMasterFlag,
    input wire logic [IRQS-1:0] interruptLatch,
    input wire logic [IRQS-1:0] individualEnableFlag,
    input wire logic watchdogIrq,
    output logic cpuHalt,
    output logic watchdogHalt,
    output logic periphHalt,
    output logic prescalerClear,
    output logic fastOscOn,
    output logic slowOscOn,
    output logic slowClockSel,
    output logic portHighZ,
    output logic [15:0] resumeAddr,
    output logic resumePulse,
    output logic servicePulse
);
    initial begin
        if (IRQS < 1 || IRQS > 32) begin
            $error("IRQS out of range");
        end
    end

    lpm_state_t state_r;
    logic [7:0] sysCtl1_r;
    logic [7:0] sysCtl2_r;
    logic [7:0] wakeCtl_r;
    logic relmEff_r;
    logic stopMeta_r, stopSync_r, stopPrev_r;
    logic [KEYS-1:0] keyMeta_r, keySync_r;
    logic awHeld_r, wHeld_r;
    logic [7:0] awIdx_r;
    logic [31:0] wData_r;
    logic wLane0_r;
    logic warmDone;

    // Pin synchronisers; the edge detector only sees the second stage
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            // Release level, so a pin already high shows no false rise
            stopMeta_r <= 1'b1;
            stopSync_r <= 1'b1;
            stopPrev_r <= 1'b1;
            keyMeta_r <= '1;
            keySync_r <= '1;
        end else begin
            stopMeta_r <= stopPinN;
            stopSync_r <= stopMeta_r;
            stopPrev_r <= stopSync_r;
            keyMeta_r <= keyWakeupInputs;
            keySync_r <= keyMeta_r;
        end
    end

    logic stopRise;
    logic levelRelease;
    logic wrFire;
    logic stopWrite;
    logic haltWrite;
    logic [IRQS-1:0] wakeIrq;
    logic anyWake;
    assign stopRise = stopSync_r && !stopPrev_r;
    // Keys take part only in level mode; edge mode ignores them
    assign levelRelease = stopSync_r ||
        |(~keySync_r & wakeCtl_r[WK_LO +: KEYS]);
    assign wrFire = awHeld_r && wHeld_r && !s_axi_bvalid;
    assign stopWrite = wrFire && wLane0_r && awIdx_r == IDX_SYSCTL1 &&
        wData_r[SC1_STOP] && state_r == ST_RUN;
    assign haltWrite = wrFire && wLane0_r && awIdx_r == IDX_SYSCTL2 &&
        wData_r[SC2_HALT] && state_r == ST_RUN;
    assign wakeIrq = interruptLatch & individualEnableFlag;
    assign anyWake = |wakeIrq;

    function automatic logic mapped(input logic [7:0] idx);
        mapped = idx == IDX_SYSCTL1 || idx == IDX_SYSCTL2 ||
            idx == IDX_WAKECTL || idx == IDX_STATUS;
    endfunction

    // Warm-up length lookup, fast column or slow column
    function automatic logic [WARM_W-1:0] warmCount(
        input logic [2:0] sel,
        input logic toSlow
    );
        logic [WARM_W-1:0] v;
        v = WARM_FAST_1X10;
        if (sel[0]) begin
            v = sel[1] ? (toSlow ? WARM_SLOW_1X6 : WARM_FAST_1X10)
                       : (toSlow ? WARM_SLOW_3X6 : WARM_FAST_3X10);
        end else begin
            unique case (sel[2:1])
                2'b00: v = toSlow ? WARM_SLOW_3X13 : WARM_FAST_3X16;
                2'b01: v = toSlow ? WARM_SLOW_1X13 : WARM_FAST_1X16;
                2'b10: v = toSlow ? WARM_SLOW_3X6 : WARM_FAST_3X14;
                2'b11: v = toSlow ? WARM_SLOW_1X6 : WARM_FAST_1X14;
            endcase
        end
        warmCount = v;
    endfunction

    // Mode sequencer
    logic enterWarm;
    logic stopReleased;
    assign stopReleased = relmEff_r ? levelRelease : stopRise;
    assign enterWarm = (state_r == ST_RUN && stopWrite && relmEff_r &&
        levelRelease) || (state_r == ST_STOP && stopReleased);
    // A stop write that skips STOP must time with the value it writes
    logic [2:0] wutSel;
    logic retSel;
    assign wutSel = stopWrite ? wData_r[SC1_WUT_HI:SC1_WUT_LO]
        : sysCtl1_r[SC1_WUT_HI:SC1_WUT_LO];
    assign retSel = stopWrite ? wData_r[SC1_STOP_RETURN_MODE] : sysCtl1_r[SC1_STOP_RETURN_MODE];

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_r <= ST_RUN;
        end else begin
            unique case (state_r)
                ST_RUN: begin
                    if (stopWrite) begin
                        state_r <= (relmEff_r && levelRelease) ?
                            ST_WARM : ST_STOP;
                    end else if (haltWrite && !watchdogIrq) begin
                        state_r <= ST_HALT;
                    end
                end
                ST_STOP: begin
                    if (stopReleased) begin
                        state_r <= ST_WARM;
                    end
                end
                ST_WARM: begin
                    // No path back to STOP once warm-up runs
                    if (warmDone) begin
                        state_r <= ST_RUN;
                    end
                end
                ST_HALT: begin
                    if (anyWake) begin
                        state_r <= ST_RUN;
                    end
                end
            endcase
        end
    end

    // Effective release method lags a switch to level until a rise
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            relmEff_r <= 1'b0;
        end else if (!sysCtl1_r[SC1_STOP_RELEASE_METHOD]) begin
            relmEff_r <= 1'b0;
        end else if (stopRise) begin
            relmEff_r <= 1'b1;
        end
    end

    warmup_counter #(
        .WIDTH(WARM_W)
    ) u_warm (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .load(enterWarm),
        .loadValue(warmCount(wutSel, retSel)),
        .tick(sysCtl1_r[SC1_STOP_RETURN_MODE] ? slowTick : 1'b1),
        .done(warmDone)
    );

    // Control registers: software writes and hardware side effects
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sysCtl1_r <= SC1_RESET;
            sysCtl2_r <= SC2_RESET;
            wakeCtl_r <= WK_RESET;
        end else begin
            if (wrFire && wLane0_r) begin
                if (awIdx_r == IDX_SYSCTL1 && state_r == ST_RUN) begin
                    sysCtl1_r <= wData_r[7:0] & SC1_WMASK;
                end
                if (awIdx_r == IDX_SYSCTL2 && state_r == ST_RUN) begin
                    sysCtl2_r <= wData_r[7:0] & SC2_WMASK;
                end
                if (awIdx_r == IDX_WAKECTL) begin
                    wakeCtl_r <= wData_r[7:0];
                end
            end
            if (state_r == ST_RUN && haltWrite && watchdogIrq) begin
                sysCtl2_r[SC2_HALT] <= 1'b0;
            end
            if (enterWarm && retSel) begin
                sysCtl2_r[SC2_XEN] <= 1'b0;
                sysCtl2_r[SC2_SYSCK] <= 1'b1;
            end
            if (enterWarm && !retSel) begin
                sysCtl2_r[SC2_SYSCK] <= 1'b0;
            end
            if (state_r == ST_WARM && warmDone) begin
                sysCtl1_r[SC1_STOP] <= 1'b0;
            end
            if (state_r == ST_HALT && anyWake) begin
                sysCtl2_r[SC2_HALT] <= 1'b0;
            end
        end
    end

    // Mode outputs, all registered
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cpuHalt <= 1'b0;
            watchdogHalt <= 1'b0;
            periphHalt <= 1'b0;
            prescalerClear <= 1'b0;
            fastOscOn <= 1'b1;
            slowOscOn <= 1'b0;
            slowClockSel <= 1'b0;
            portHighZ <= 1'b0;
        end else begin
            cpuHalt <= state_r != ST_RUN;
            watchdogHalt <= state_r != ST_RUN;
            periphHalt <= state_r == ST_STOP || state_r == ST_WARM;
            prescalerClear <= state_r == ST_STOP ||
                state_r == ST_WARM;
            // Oscillators follow the enable bits except while stopped
            fastOscOn <= sysCtl2_r[SC2_XEN] && state_r != ST_STOP;
            slowOscOn <= sysCtl2_r[SC2_XTEN] && state_r != ST_STOP;
            slowClockSel <= sysCtl2_r[SC2_SYSCK];
            portHighZ <= state_r == ST_STOP && !sysCtl1_r[SC1_OUTEN];
        end
    end

    // Resume address and resume/service strobes toward the CPU
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            resumeAddr <= 16'h0000;
            resumePulse <= 1'b0;
            servicePulse <= 1'b0;
        end else begin
            if (stopWrite || (haltWrite && !watchdogIrq)) begin
                resumeAddr <= instrAddr + 16'h0002;
            end
            resumePulse <= (state_r == ST_WARM && warmDone) ||
                (state_r == ST_HALT && anyWake &&
                 !interruptMasterFlag);
            servicePulse <= state_r == ST_HALT && anyWake &&
                interruptMasterFlag;
        end
    end

    // AXI4-Lite write side; address and data taken in either order
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            awHeld_r <= 1'b0;
            wHeld_r <= 1'b0;
            awIdx_r <= 8'h00;
            wData_r <= 32'h0000_0000;
            wLane0_r <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_r <= 1'b1;
                awIdx_r <= s_axi_awaddr[9:2];
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_r <= 1'b1;
                wData_r <= s_axi_wdata;
                wLane0_r <= s_axi_wstrb[0];
                s_axi_wready <= 1'b0;
            end
            if (wrFire) begin
                awHeld_r <= 1'b0;
                wHeld_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= (mapped(awIdx_r) && awIdx_r != IDX_STATUS)
                    ? RESP_OKAY : RESP_SLVERR;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    // AXI4-Lite read side
    logic [31:0] rdMux;
    always_comb begin
        rdMux = 32'h0000_0000;
        unique case (s_axi_araddr[9:2])
            IDX_SYSCTL1: rdMux[7:0] = sysCtl1_r;
            IDX_SYSCTL2: rdMux[7:0] = sysCtl2_r;
            IDX_WAKECTL: rdMux[7:0] = wakeCtl_r;
            IDX_STATUS: begin
                rdMux[ST_STATE_LO +: 4] = state_r;
                rdMux[ST_STOP_RELEASE_METHOD_EFF] = relmEff_r;
                rdMux[ST_FASTOSC] = fastOscOn;
                rdMux[ST_SLOWOSC] = slowOscOn;
            end
            default: rdMux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rdMux;
            s_axi_rresp <= mapped(s_axi_araddr[9:2]) ? RESP_OKAY
                                                     : RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // Checks
    a_stop_entry: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (stopWrite && !(relmEff_r && levelRelease)) |=> state_r == ST_STOP)
        else $error("stop write did not enter STOP");
    a_stop_osc_off: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_r == ST_STOP [*2] |-> !fastOscOn && !slowOscOn && periphHalt)
        else $error("oscillator running in STOP");
    a_tg_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
        $rose(state_r == ST_STOP) |=> prescalerClear)
        else $error("prescaler not cleared in STOP");
    a_resume_addr: assert property (@(posedge sys_clk) disable iff (!rst_n)
        stopWrite |=> resumeAddr == $past(instrAddr) + 16'h0002)
        else $error("resume address not start plus two");
    a_level_skip: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (stopWrite && relmEff_r && levelRelease) |=> state_r == ST_WARM)
        else $error("level release did not skip STOP");
    a_no_reentry: assert property (@(posedge sys_clk) disable iff (!rst_n)
        state_r == ST_WARM |=> state_r inside {ST_WARM, ST_RUN})
        else $error("warm-up fell back into STOP");
    a_edge_hold: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_r == ST_STOP && !relmEff_r && !stopRise)
        |=> state_r == ST_STOP)
        else $error("edge mode left STOP without a rise");
    a_warm_resume: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_r == ST_WARM && warmDone)
        |=> resumePulse && state_r == ST_RUN ##1 !cpuHalt)
        else $error("warm-up end did not resume");
    a_halt_clear: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_r == ST_HALT && anyWake)
        |=> !sysCtl2_r[SC2_HALT] && state_r == ST_RUN)
        else $error("halt exit left request bit set");
    a_service: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (state_r == ST_HALT && anyWake)
        |=> servicePulse == $past(interruptMasterFlag) &&
            resumePulse == !$past(interruptMasterFlag))
        else $error("wrong halt release kind");
    a_wdt_block: assert property (@(posedge sys_clk) disable iff (!rst_n)
        (haltWrite && watchdogIrq) |=> state_r != ST_HALT)
        else $error("halt entered despite watchdog interrupt");
endmodule

// ==== wake_partner.sv ====
// Purpose: Far-side model of the stop pin and the key wakeup pins
// Assumes: The bench asks for levels; pins move just after an edge
// Notes: Keys stay high unless a level-release scenario asks
`timescale 1ns/1ps
module wake_partner
    import lpm_pkg::*;
(
    input wire logic sys_clk,
    input wire logic pinLevel,
    input wire logic [KEYS-1:0] keyLevel,
    output logic stopPinN,
    output logic [KEYS-1:0] keyWakeupInputs
);
    initial begin
        stopPinN = 1'b0;
        keyWakeupInputs = '1;
    end
    always @(posedge sys_clk) begin
        stopPinN <= pinLevel;
        keyWakeupInputs <= keyLevel;
    end
endmodule

// ==== tb_top.sv ====
// Purpose: Self-checking bench for the low-power mode controller
// Assumes: Long fast warm-up counts shortened to 16 cycles by parameter
// Notes: Handshakes are read at the falling edge, where they are settled
`timescale 1ns/1ps
module tb_top
    import lpm_pkg::*;
();
    logic sys_clk, rst_n, awv, wv, bry, arv, rry, slowTick, interrupt_master_flag, wdi, pinL, s;
    logic awr, wr_, bv, arr, rv, stopN, cH, wH, pH, pc, fo, so, scs, hz, rp, sp;
    logic [9:0] awa, ara;
    logic [31:0] wd, rd, d;
    logic [15:0] ia, ea, ra;
    logic [7:0] lat, en, e;
    logic [3:0] keyL, keys, ws;
    logic r;
    logic [1:0] br, rr, resp;
    int errors, check_count, seed, cyc, n, k;
    wake_partner far (.sys_clk(sys_clk), .pinLevel(pinL), .keyLevel(keyL),
        .stopPinN(stopN), .keyWakeupInputs(keys));
    // Long slow counts keep their defaults; only code 011 returns slow
    low_power_mode_control #(.WARM_FAST_3X16(18'h0_0010),
        .WARM_FAST_1X16(18'h0_0010), .WARM_FAST_3X14(18'h0_0010),
        .WARM_FAST_1X14(18'h0_0010)) dut (.sys_clk(sys_clk), .rst_n(rst_n),
        .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
        .s_axi_wready(wr_), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
        .s_axi_rvalid(rv), .s_axi_rready(rry), .stopPinN(stopN),
        .keyWakeupInputs(keys), .slowTick(slowTick), .instrAddr(ia),
        .interruptMasterFlag(interrupt_master_flag), .interruptLatch(lat),
        .individualEnableFlag(en), .watchdogIrq(wdi), .cpuHalt(cH),
        .watchdogHalt(wH), .periphHalt(pH), .prescalerClear(pc),
        .fastOscOn(fo), .slowOscOn(so), .slowClockSel(scs), .portHighZ(hz),
        .resumeAddr(ra), .resumePulse(rp), .servicePulse(sp));
    // Warm-up length in fast cycles for each select code
    function automatic int wcnt(input int c);
        return (c[0] == 0) ? 16 : (c[1] ? 1024 : 3072);
    endfunction
    task summarize();
        if (errors == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] x);
        check_count++;
        if (g !== x) begin
            errors++;
            $display("BAD %0t got %h exp %h", $time, g, x);
        end
    endtask
    // Start address is random so a stuck resume address shows up
    task wr(input logic [7:0] i, input logic [31:0] v);
        logic a, w, b;
        @(posedge sys_clk);
        ea = 16'($random(seed));
        ia <= ea;
        ea = ea + 16'h0002;
        awa <= {i, 2'b00};
        wd <= v;
        awv <= 1'b1;
        wv <= 1'b1;
        bry <= 1'b1;
        b = 1'b0;
        while (!b) begin
            @(negedge sys_clk);
            a = awv & awr;
            w = wv & wr_;
            b = bv;
            resp = br;
            @(posedge sys_clk);
            if (a) awv <= 1'b0;
            if (w) wv <= 1'b0;
            if (b) bry <= 1'b0;
        end
    endtask
    task rchk(input logic [7:0] i, input logic [31:0] x);
        logic a, b;
        @(posedge sys_clk);
        ara <= {i, 2'b00};
        arv <= 1'b1;
        rry <= 1'b1;
        b = 1'b0;
        while (!b) begin
            @(negedge sys_clk);
            a = arv & arr;
            b = rv;
            d = rd;
            resp = rr;
            @(posedge sys_clk);
            if (a) arv <= 1'b0;
            if (b) rry <= 1'b0;
        end
        chk(d, x);
    endtask
    task waitp(input int lim);
        n = 0;
        do begin
            @(negedge sys_clk);
            n++;
        end while (n < lim && rp !== 1'b1 && sp !== 1'b1);
        s = sp;
        r = rp;
        // Hand back on a rising edge so callers drive inputs there
        @(posedge sys_clk);
    endtask
    task rise();
        @(posedge sys_clk);
        pinL <= 1'b0;
        repeat (4) @(posedge sys_clk);
        pinL <= 1'b1;
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    always @(posedge sys_clk) begin
        slowTick <= ($random(seed) & 3) == 0;
        cyc++;
        if (cyc > 40000) begin
            errors++;
            summarize();
        end
    end
    initial begin
        {errors, check_count, cyc, seed} = {32'd0, 32'd0, 32'd0, 32'd45};
        {rst_n, awv, wv, bry, arv, rry, interrupt_master_flag, wdi} = '0;
        {awa, ara, wd, ia, lat, en} = '0;
        ws = 4'hf;
        pinL = 1'b1;
        keyL = 4'hf;
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        rchk(IDX_SYSCTL1, 32'h0000_0000);
        rchk(IDX_SYSCTL2, 32'h0000_0080);
        rchk(IDX_STATUS, 32'h0000_0021);
        rchk(8'h00, 32'h0000_0000);
        chk(resp, RESP_SLVERR);
        wr(IDX_STATUS, 32'h0000_00ff);
        chk(resp, RESP_SLVERR);
        ws <= 4'he;
        wr(IDX_SYSCTL1, 32'h0000_0080);
        ws <= 4'hf;
        chk(resp, RESP_OKAY);
        rchk(IDX_SYSCTL1, 32'h0000_0000);
        for (int c = 0; c < 8; c++) begin
            wr(IDX_SYSCTL1, 32'h0000_0080 | c);
            rchk(IDX_STATUS, 32'h0000_0002);
            chk(pc, 1'b1);
            chk(hz, 1'b1);
            rise();
            waitp(wcnt(c) + 20);
            chk(32'(n >= wcnt(c) && n <= wcnt(c) + 12), 32'h1);
            chk(ra, ea);
            rchk(IDX_SYSCTL1, 32'(c));
        end
        wr(IDX_SYSCTL1, 32'h0000_0040);
        rchk(IDX_STATUS, 32'h0000_0021);
        rise();
        repeat (4) @(posedge sys_clk);
        rchk(IDX_STATUS, 32'h0000_0031);
        pinL <= 1'b0;
        k = $random(seed) & 3;
        wr(IDX_WAKECTL, 32'h0000_0001 << (WK_LO + k));
        wr(IDX_SYSCTL1, 32'h0000_00c3);
        rchk(IDX_STATUS, 32'h0000_0012);
        keyL <= ~(4'h1 << k);
        waitp(1044);
        chk(32'(r), 32'h1);
        keyL <= 4'hf;
        pinL <= 1'b1;
        repeat (4) @(posedge sys_clk);
        // Select 000 must time this warm-up, not the stored 011
        wr(IDX_SYSCTL1, 32'h0000_00c0);
        pinL <= 1'b0;
        rchk(IDX_STATUS, 32'h0000_0034);
        waitp(40);
        chk(32'(r), 32'h1);
        for (int m = 0; m < 2; m++) begin
            e = 8'h01 << ($random(seed) & 7);
            en <= e;
            interrupt_master_flag <= m[0];
            wr(IDX_SYSCTL2, 32'h0000_0090);
            repeat (2) @(posedge sys_clk);
            chk({cH, wH, pH}, 3'b110);
            lat <= e;
            waitp(10);
            chk(32'(s), 32'(m));
            chk(32'(r | s), 32'h1);
            chk(ra, ea);
            @(posedge sys_clk);
            lat <= 8'h00;
            rchk(IDX_SYSCTL2, 32'h0000_0080);
        end
        wdi <= 1'b1;
        wr(IDX_SYSCTL2, 32'h0000_0090);
        repeat (2) @(posedge sys_clk);
        chk(cH, 1'b0);
        rchk(IDX_SYSCTL2, 32'h0000_0080);
        wdi <= 1'b0;
        // Dual clock, slow return with select 011: 64 slow ticks
        wr(IDX_SYSCTL2, 32'h0000_00c0);
        wr(IDX_SYSCTL1, 32'h0000_00a3);
        rise();
        waitp(1000);
        chk(32'(r && n >= 64), 32'h1);
        rchk(IDX_SYSCTL2, 32'h0000_0060);
        rchk(IDX_STATUS, 32'h0000_0041);
        chk(scs, 1'b1);
        // Reset lands in mid-STOP, so no warm-up path may follow it
        wr(IDX_SYSCTL1, 32'h0000_0083);
        rst_n <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        rchk(IDX_SYSCTL1, 32'h0000_0000);
        rchk(IDX_STATUS, 32'h0000_0021);
        summarize();
    end
endmodule
